// *** verilog/conv_pkg.sv ***
package conv_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int PG_LOW_NS        = 50000;
  // whole cycles of the system clock, never below one
  localparam int PG_LOW_CYCLES    = (PG_LOW_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : (PG_LOW_NS / CLK_PERIOD_NS);
  localparam int LINK_HALF_CYCLES = 4;

  // ---------------------------------------------------------------
  // divider codes and read-back layout
  // ---------------------------------------------------------------
  localparam int          VID_W        = 5;
  localparam logic [4:0]  VID_RESET    = 5'h1f;
  localparam int          RB_VID_LSB   = 3;
  localparam int          RB_STAT_BIT  = 2;
  localparam logic        OFF_RESET    = 1'b1;

  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_SETUP = 2'h1,
    KIND_ON    = 2'h2,
    KIND_OFF   = 2'h3
  } kind_type;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] CTRL_OFFSET    = 12'h000;
  localparam logic [11:0] CMD_OFFSET     = 12'h004;
  localparam logic [11:0] STATUS_OFFSET  = 12'h008;
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_SEL_BIT   = 1;
  localparam int          CMD_KIND_LSB   = 0;
  localparam int          CMD_LO_LSB     = 8;
  localparam int          CMD_HI_LSB     = 16;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_RBLO_LSB  = 8;
  localparam int          STAT_RBHI_LSB  = 16;

  function automatic logic [7:0] pack_readback(input logic [4:0] vid, input logic off);
    pack_readback = {vid, off, 2'h0};
  endfunction

endpackage

// *** verilog/conv_link_if.sv ***
`timescale 1ns/10ps
interface conv_link_if;
  logic       link_clk;
  logic       frame_valid;
  logic [1:0] frame_kind;
  logic [4:0] frame_lo;
  logic [4:0] frame_hi;
  logic       global_run_input;
  logic       setting_select;
  logic [7:0] readback_lo;
  logic [7:0] readback_hi;

  modport device (
    input  link_clk,
    input  frame_valid,
    input  frame_kind,
    input  frame_lo,
    input  frame_hi,
    input  global_run_input,
    input  setting_select,
    output readback_lo,
    output readback_hi
  );

  modport host (
    output link_clk,
    output frame_valid,
    output frame_kind,
    output frame_lo,
    output frame_hi,
    output global_run_input,
    output setting_select,
    input  readback_lo,
    input  readback_hi
  );
endinterface

// *** verilog/pg_timer.sv ***
`timescale 1ns/10ps
module pg_timer #(
  parameter int CYCLES = conv_pkg::PG_LOW_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      busy
);

  logic [$clog2(CYCLES+1)-1:0] count_q;
  logic [$clog2(CYCLES+1)-1:0] count_d;

  // a new trigger restarts the full interval
  always_comb
  begin
    count_d = count_q;
    if (trigger)
      count_d = ($clog2(CYCLES+1))'(CYCLES);
    else if (count_q != '0)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign busy = (count_q != '0);

endmodule

// *** verilog/conv_device.sv ***
// Notes on behaviour
// - off status is NAND of run and on-state
// - off status pulls enables and power-good low
// - off status low releases the enables
// - off falling edge holds power-good low 50us
// - select toggle restarts the power-good timer
// - reset returns the command interface to idle
// - reset sets both divider codes to ones
// - reset presets the off status high
// - host lowers run first, picks select
// - host sets up both codes before turning on
// - host verifies read-back, repeats setup if wrong
// - two consecutive on commands set on-state
// - read-back carries off status bit
// - host raises run after the on commands; off reads low only then
// - two offs or run low shut down
// - reduced-pin variant ties run high internally
// - on commands ignored before setup
// - select high picks code 1, low code 0
`timescale 1ns/10ps
module conv_device #(
  parameter bit REDUCED_PIN = 1'b0,
  parameter int PG_CYCLES   = conv_pkg::PG_LOW_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  conv_link_if.device     link,
  output logic [2:0]      CONV_EN_O,
  output logic [2:0]      CONV_EN_OE,
  output logic            POWER_GOOD_O,
  output logic            POWER_GOOD_OE,
  output logic [4:0]      ACTIVE_VID
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 16;

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] sync_in;

  assign sync_in = {link.link_clk, link.frame_valid, link.frame_kind,
                    link.frame_lo, link.frame_hi,
                    link.global_run_input, link.setting_select};

  // first stage feeds only the second stage
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= sync_in;
      sync_q <= meta_q;
    end
  end

  logic       lclk_s;
  logic       valid_s;
  logic [1:0] kind_s;
  logic [4:0] lo_s;
  logic [4:0] hi_s;
  logic       run_pin_s;
  logic       sel_s;

  assign {lclk_s, valid_s, kind_s, lo_s, hi_s, run_pin_s, sel_s} = sync_q;

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic lclk_prev_q;
  logic sel_prev_q;
  logic lclk_prev_d;
  logic sel_prev_d;
  logic frame_take;
  logic sel_toggle;
  logic run_eff;

  always_comb
  begin
    lclk_prev_d = lclk_s;
    sel_prev_d  = sel_s;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      lclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b0;
    end
    else
    begin
      lclk_prev_q <= lclk_prev_d;
      sel_prev_q  <= sel_prev_d;
    end
  end

  // frame fields settle half a link period before the rising edge
  assign frame_take = lclk_s & ~lclk_prev_q & valid_s;
  assign sel_toggle = sel_s ^ sel_prev_q;
  // pin-starved package: run is fixed high, bus commands alone switch
  assign run_eff    = REDUCED_PIN ? 1'b1 : run_pin_s;

  // ---------------------------------------------------------------
  // on/off sequencer and divider registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_ONE_ON  = 2'b01,
    SEQ_ONE_OFF = 2'b10
  } seq_type;

  seq_type    seq_q;
  seq_type    seq_d;
  logic       on_state_q;
  logic       on_state_d;
  logic       setup_done_q;
  logic       setup_done_d;
  logic [4:0] code0_q;
  logic [4:0] code0_d;
  logic [4:0] code1_q;
  logic [4:0] code1_d;
  logic       off_q;
  logic       off_d;
  logic       locked;

  // codes are frozen while converters run
  assign locked = on_state_q & run_eff;

  always_comb
  begin
    seq_d        = seq_q;
    on_state_d   = on_state_q;
    setup_done_d = setup_done_q;
    code0_d      = code0_q;
    code1_d      = code1_q;
    if (frame_take)
    begin
      case (conv_pkg::kind_type'(kind_s))
        conv_pkg::KIND_SETUP:
        begin
          seq_d = SEQ_IDLE;
          if (!locked)
          begin
            code0_d      = lo_s;
            code1_d      = hi_s;
            setup_done_d = 1'b1;
          end
        end
        conv_pkg::KIND_ON:
        begin
          if (!setup_done_q)
            seq_d = SEQ_IDLE;
          else if (seq_q == SEQ_ONE_ON)
          begin
            on_state_d = 1'b1;
            seq_d      = SEQ_IDLE;
          end
          else
            seq_d = SEQ_ONE_ON;
        end
        conv_pkg::KIND_OFF:
        begin
          if (seq_q == SEQ_ONE_OFF)
          begin
            on_state_d = 1'b0;
            seq_d      = SEQ_IDLE;
          end
          else
            seq_d = SEQ_ONE_OFF;
        end
        // any other protocol breaks a pair
        default:
          seq_d = SEQ_IDLE;
      endcase
    end
    off_d = ~(run_eff & on_state_d);
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      seq_q        <= SEQ_IDLE;
      on_state_q   <= 1'b0;
      setup_done_q <= 1'b0;
      code0_q      <= conv_pkg::VID_RESET;
      code1_q      <= conv_pkg::VID_RESET;
      off_q        <= conv_pkg::OFF_RESET;
    end
    else
    begin
      seq_q        <= seq_d;
      on_state_q   <= on_state_d;
      setup_done_q <= setup_done_d;
      code0_q      <= code0_d;
      code1_q      <= code1_d;
      off_q        <= off_d;
    end
  end

  // ---------------------------------------------------------------
  // power-good timer
  // ---------------------------------------------------------------
  logic pg_busy;
  logic pg_trigger;

  assign pg_trigger = (off_q & ~off_d) | sel_toggle;

  pg_timer #(
    .CYCLES (PG_CYCLES)
  ) u_pg_timer (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .trigger (pg_trigger),
    .busy    (pg_busy)
  );

  // ---------------------------------------------------------------
  // pins and read-back
  // ---------------------------------------------------------------
  logic [2:0] en_oe_q;
  logic [2:0] en_oe_d;
  logic       pg_oe_q;
  logic       pg_oe_d;
  logic [4:0] vid_q;
  logic [4:0] vid_d;
  logic [7:0] rb_lo_q;
  logic [7:0] rb_lo_d;
  logic [7:0] rb_hi_q;
  logic [7:0] rb_hi_d;

  always_comb
  begin
    en_oe_d = {3{off_d}};
    pg_oe_d = off_d | pg_trigger | pg_busy;
    vid_d   = sel_s ? code1_d : code0_d;
    rb_lo_d = conv_pkg::pack_readback(code0_d, off_d);
    rb_hi_d = conv_pkg::pack_readback(code1_d, off_d);
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      en_oe_q <= 3'h7;
      pg_oe_q <= 1'b1;
      vid_q   <= conv_pkg::VID_RESET;
      rb_lo_q <= 8'hfc;
      rb_hi_q <= 8'hfc;
    end
    else
    begin
      en_oe_q <= en_oe_d;
      pg_oe_q <= pg_oe_d;
      vid_q   <= vid_d;
      rb_lo_q <= rb_lo_d;
      rb_hi_q <= rb_hi_d;
    end
  end

  // open drain: the driven level is always ground
  assign CONV_EN_O        = 3'h0;
  assign POWER_GOOD_O     = 1'b0;
  assign CONV_EN_OE       = en_oe_q;
  assign POWER_GOOD_OE    = pg_oe_q;
  assign ACTIVE_VID       = vid_q;
  assign link.readback_lo = rb_lo_q;
  assign link.readback_hi = rb_hi_q;

endmodule

// *** verilog/conv_host.sv ***
`timescale 1ns/10ps
module conv_host #(
  parameter int HALF_CYCLES = conv_pkg::LINK_HALF_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  conv_link_if.host        link,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  // ---------------------------------------------------------------
  // link clock divider
  // ---------------------------------------------------------------
  logic [$clog2(HALF_CYCLES)-1:0] div_q;
  logic [$clog2(HALF_CYCLES)-1:0] div_d;
  logic                           lclk_q;
  logic                           lclk_d;
  logic                           fall_now;

  assign fall_now = lclk_q & (div_q == '0);

  always_comb
  begin
    div_d  = div_q - 1'b1;
    lclk_d = lclk_q;
    if (div_q == '0)
    begin
      div_d  = ($clog2(HALF_CYCLES))'(HALF_CYCLES - 1);
      lclk_d = ~lclk_q;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      div_q  <= '0;
      lclk_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      lclk_q <= lclk_d;
    end
  end

  // ---------------------------------------------------------------
  // read-back synchronisers
  // ---------------------------------------------------------------
  logic [15:0] rb_meta_q;
  logic [15:0] rb_q;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      rb_meta_q <= '0;
      rb_q      <= '0;
    end
    else
    begin
      rb_meta_q <= {link.readback_hi, link.readback_lo};
      rb_q      <= rb_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // apb slave and command engine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_GAP  = 2'b11
  } host_type;

  host_type    st_q;
  host_type    st_d;
  logic        repeat_q;
  logic        repeat_d;
  logic [11:0] cmd_q;
  logic [11:0] cmd_d;
  logic        valid_q;
  logic        valid_d;
  logic [11:0] frame_q;
  logic [11:0] frame_d;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic        ready_q;
  logic        ready_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        access;
  logic        busy;

  assign access = PSEL & PENABLE & ~ready_q;
  assign busy   = (st_q != ST_IDLE);

  always_comb
  begin
    st_d     = st_q;
    repeat_d = repeat_q;
    cmd_d    = cmd_q;
    valid_d  = valid_q;
    frame_d  = frame_q;
    ctrl_d   = ctrl_q;
    ready_d  = access;
    err_d    = 1'b0;
    rdata_d  = rdata_q;
    if (access)
    begin
      rdata_d = '0;
      case (PADDR)
        conv_pkg::CTRL_OFFSET:
        begin
          rdata_d[1:0] = ctrl_q;
          if (PWRITE)
            ctrl_d = {PWDATA[conv_pkg::CTRL_SEL_BIT], PWDATA[conv_pkg::CTRL_RUN_BIT]};
        end
        conv_pkg::CMD_OFFSET:
        begin
          // a command while one is in flight is refused
          if (PWRITE && busy)
            err_d = 1'b1;
          else if (PWRITE)
          begin
            cmd_d    = {PWDATA[conv_pkg::CMD_HI_LSB +: 5], PWDATA[conv_pkg::CMD_LO_LSB +: 5],
                        PWDATA[conv_pkg::CMD_KIND_LSB +: 2]};
            repeat_d = (PWDATA[conv_pkg::CMD_KIND_LSB +: 2] == conv_pkg::KIND_ON)
                     | (PWDATA[conv_pkg::CMD_KIND_LSB +: 2] == conv_pkg::KIND_OFF);
            st_d     = ST_GAP;
          end
        end
        conv_pkg::STATUS_OFFSET:
        begin
          rdata_d[conv_pkg::STAT_BUSY_BIT]     = busy;
          rdata_d[conv_pkg::STAT_RBLO_LSB +: 8] = rb_q[7:0];
          rdata_d[conv_pkg::STAT_RBHI_LSB +: 8] = rb_q[15:8];
        end
        default:
          err_d = 1'b1;
      endcase
    end
    // frames change only as the link clock falls
    if (fall_now)
    begin
      case (st_q)
        ST_GAP:
        begin
          valid_d = 1'b1;
          // fields launch with valid, so a write never disturbs a high phase
          frame_d = cmd_q;
          st_d    = ST_SEND;
        end
        ST_SEND:
        begin
          valid_d  = 1'b0;
          repeat_d = 1'b0;
          st_d     = repeat_q ? ST_GAP : ST_IDLE;
        end
        default:
          valid_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      st_q     <= ST_IDLE;
      repeat_q <= 1'b0;
      cmd_q    <= '0;
      valid_q  <= 1'b0;
      frame_q  <= '0;
      ctrl_q   <= 2'h0;
      ready_q  <= 1'b0;
      err_q    <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      st_q     <= st_d;
      repeat_q <= repeat_d;
      cmd_q    <= cmd_d;
      valid_q  <= valid_d;
      frame_q  <= frame_d;
      ctrl_q   <= ctrl_d;
      ready_q  <= ready_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
    end
  end

  assign link.link_clk         = lclk_q;
  assign link.frame_valid      = valid_q;
  assign link.frame_kind       = frame_q[1:0];
  assign link.frame_lo         = frame_q[6:2];
  assign link.frame_hi         = frame_q[11:7];
  assign link.global_run_input = ctrl_q[0];
  assign link.setting_select   = ctrl_q[1];
  assign PRDATA                = rdata_q;
  assign PREADY                = ready_q;
  assign PSLVERR               = err_q;

endmodule

// *** verification/conv_link_assertions.sv ***
`timescale 1ns/10ps
module conv_link_assertions (
  input logic       MCLK,
  input logic       RST_N,
  input logic       link_clk,
  input logic       frame_valid,
  input logic [1:0] frame_kind,
  input logic [4:0] frame_lo,
  input logic [4:0] frame_hi,
  input logic       global_run_input,
  input logic       setting_select,
  input logic [7:0] readback_lo,
  input logic [7:0] readback_hi
);
  // ----
  // read-back
  // ----
  a_reset_preset: assert property (
    @(posedge MCLK) !RST_N |=> readback_lo == 8'hfc && readback_hi == 8'hfc)
    else $error("read-back not preset by reset");
  a_spare_zero: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    readback_lo[1:0] == 2'h0 && readback_hi[1:0] == 2'h0)
    else $error("read-back spare bits not zero");
  a_off_match: assert property (
    @(posedge MCLK) disable iff (!RST_N) readback_lo[2] == readback_hi[2])
    else $error("off status differs between bytes");
  a_run_low_off: assert property (
    @(posedge MCLK) disable iff (!RST_N) !global_run_input [*8] |-> readback_lo[2])
    else $error("off status low while run low");
  a_on_needs_run: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    $fell(readback_lo[2]) |-> $past(global_run_input, 3))
    else $error("off status fell without run");
  // codes move only by a setup frame, with the frame's own values
  a_code_setup: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    $changed(readback_lo[7:3]) || $changed(readback_hi[7:3]) |->
      $past(frame_valid, 3) && $past(frame_kind, 3) == conv_pkg::KIND_SETUP
      && readback_lo[7:3] == $past(frame_lo, 3) && readback_hi[7:3] == $past(frame_hi, 3))
    else $error("code changed without setup frame");
  // ----
  // link framing
  // ----
  a_frame_hold: assert property (
    @(posedge MCLK) disable iff (!RST_N) link_clk && $past(link_clk) |->
      $stable(frame_valid) && $stable(frame_kind) && $stable(frame_lo) && $stable(frame_hi))
    else $error("frame changed while link clock high");
  a_link_half: assert property (
    @(posedge MCLK) disable iff (!RST_N) $rose(link_clk) |=> link_clk [*3] ##1 !link_clk)
    else $error("link clock high phase wrong");
endmodule

// *** verification/converter_enable_control_tb.sv ***
`timescale 1ns/10ps
module converter_enable_control_tb;
  // ----
  // bench state
  // ----
  localparam int PG = 20;
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] lo;
    logic [4:0] hi;
    logic       run;
    logic       sel;
    logic [4:0] e_lo;
    logic [4:0] e_hi;
    logic       e_off;
  } row_type;
  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  en_o;
  logic [2:0]  en_oe;
  logic        pg_o;
  logic        pg_oe;
  logic [4:0]  vid;
  int          fail_count = 0;
  int          compares   = 0;
  int          cycles     = 0;
  row_type     rows[9];
  // open-drain lines pulled up when released
  wire  [2:0]  en_pin = (en_oe & en_o) | ~en_oe;
  wire         pg_pin = (pg_oe & pg_o) | ~pg_oe;

  always #12.5 mclk = ~mclk;

  conv_link_if link ();
  conv_host conv_host_i (.MCLK(mclk), .RST_N(rst_n), .link(link), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  conv_device #(.PG_CYCLES(PG)) conv_device_i (.MCLK(mclk), .RST_N(rst_n), .link(link),
    .CONV_EN_O(en_o), .CONV_EN_OE(en_oe), .POWER_GOOD_O(pg_o), .POWER_GOOD_OE(pg_oe),
    .ACTIVE_VID(vid));
  conv_link_assertions conv_link_assertions_i (.MCLK(mclk), .RST_N(rst_n),
    .link_clk(link.link_clk), .frame_valid(link.frame_valid),
    .frame_kind(link.frame_kind), .frame_lo(link.frame_lo), .frame_hi(link.frame_hi),
    .global_run_input(link.global_run_input), .setting_select(link.setting_select),
    .readback_lo(link.readback_lo), .readback_hi(link.readback_hi));

  // ----
  // tasks
  // ----
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // busy covers both frames of a pair; extra cycles cover the input syncs
  task settle;
    logic [31:0] r;
    logic        e;
    repeat (100)
    begin
      apb(1'b0, conv_pkg::STATUS_OFFSET, 32'h0, r, e);
      if (r[conv_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    repeat (8) @(posedge mclk);
  endtask

  task ctrl(input logic run, input logic sel);
    logic [31:0] r;
    logic        e;
    apb(1'b1, conv_pkg::CTRL_OFFSET, {30'h0, sel, run}, r, e);
    settle();
  endtask

  task cmd(input logic [1:0] k, input logic [4:0] lo, input logic [4:0] hi);
    logic [31:0] r;
    logic        e;
    apb(1'b1, conv_pkg::CMD_OFFSET, {11'h0, hi, 3'h0, lo, 6'h0, k}, r, e);
    check(e, 1'b0);
    settle();
  endtask

  // cycles of power-good low while the enables are released
  task pg_count(output int n);
    n = 0;
    repeat (100)
    begin
      @(posedge mclk);
      if (pg_pin === 1'b0 && en_pin === 3'h7) n++;
    end
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ----
  // main sequence
  // ----
  initial
  begin : main
    logic [31:0] r;
    logic        e;
    int          n;
    rows[0] = '{conv_pkg::KIND_ON,    5'h00, 5'h00, 1'b1, 1'b0, 5'h1f, 5'h1f, 1'b1};
    rows[1] = '{conv_pkg::KIND_SETUP, 5'h0a, 5'h15, 1'b0, 1'b0, 5'h0a, 5'h15, 1'b1};
    rows[2] = '{conv_pkg::KIND_ON,    5'h00, 5'h00, 1'b0, 1'b0, 5'h0a, 5'h15, 1'b1};
    rows[3] = '{conv_pkg::KIND_READ,  5'h00, 5'h00, 1'b1, 1'b0, 5'h0a, 5'h15, 1'b0};
    rows[4] = '{conv_pkg::KIND_SETUP, 5'h03, 5'h04, 1'b1, 1'b0, 5'h0a, 5'h15, 1'b0};
    rows[5] = '{conv_pkg::KIND_OFF,   5'h00, 5'h00, 1'b1, 1'b0, 5'h0a, 5'h15, 1'b1};
    rows[6] = '{conv_pkg::KIND_ON,    5'h00, 5'h00, 1'b1, 1'b1, 5'h0a, 5'h15, 1'b0};
    rows[7] = '{conv_pkg::KIND_READ,  5'h00, 5'h00, 1'b0, 1'b1, 5'h0a, 5'h15, 1'b1};
    rows[8] = '{conv_pkg::KIND_SETUP, 5'h03, 5'h04, 1'b0, 1'b1, 5'h03, 5'h04, 1'b1};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check(en_oe, 3'h7);
    check(pg_oe, 1'b1);
    check(vid, 5'h1f);
    foreach (rows[i])
    begin
      ctrl(rows[i].run, rows[i].sel);
      cmd(rows[i].kind, rows[i].lo, rows[i].hi);
      apb(1'b0, conv_pkg::STATUS_OFFSET, 32'h0, r, e);
      check(r[23:8], {rows[i].e_hi, rows[i].e_off, 2'h0, rows[i].e_lo, rows[i].e_off, 2'h0});
      check(en_pin, {3{~rows[i].e_off}});
      check(vid, rows[i].sel ? rows[i].e_hi : rows[i].e_lo);
    end
    cmd(conv_pkg::KIND_ON, 5'h00, 5'h00);
    apb(1'b1, conv_pkg::CTRL_OFFSET, 32'h3, r, e);
    pg_count(n);
    check(n >= PG && n <= PG + 2, 1'b1);
    apb(1'b1, conv_pkg::CTRL_OFFSET, 32'h1, r, e);
    pg_count(n);
    check(n >= PG && n <= PG + 2, 1'b1);
    check(vid, 5'h03);
    apb(1'b1, conv_pkg::CTRL_OFFSET, 32'h0, r, e);
    repeat (8) @(posedge mclk);
    check({en_pin, pg_pin}, 4'h0);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    check(e, 1'b1);
    ctrl(1'b1, 1'b0);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check({en_oe, pg_oe, vid}, {3'h7, 1'b1, 5'h1f});
    ctrl(1'b1, 1'b0);
    cmd(conv_pkg::KIND_ON, 5'h00, 5'h00);
    apb(1'b0, conv_pkg::STATUS_OFFSET, 32'h0, r, e);
    check(r[23:8], 16'hfcfc);
    check(en_pin, 3'h0);
    // a second command while the first is still on the link is refused
    apb(1'b1, conv_pkg::CMD_OFFSET, 32'h00150a01, r, e);
    apb(1'b1, conv_pkg::CMD_OFFSET, 32'h00000003, r, e);
    check(e, 1'b1);
    settle();
    apb(1'b0, conv_pkg::STATUS_OFFSET, 32'h0, r, e);
    check(r[23:8], 16'hac54);
    stop_test();
  end
endmodule
